// File: core/sas_cfg.svh
/*
 Timing, field and offset constants for the converter sequencer.
 Assumes inclusion by the design file and the bench by bare name.
*/
`ifndef SAS_CFG_SVH
`define SAS_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SAS_OFF_SCR      12'h000
`define SAS_OFF_RESH     12'h004
`define SAS_OFF_RESL     12'h008
`define SAS_OFF_CLKR     12'h00C
`define SAS_OFF_PORTDAT  12'h010
`define SAS_OFF_PORTDIR  12'h014
`define SAS_OFF_PORTIN   12'h018
// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define SAS_SCR_DONE     7
`define SAS_SCR_IEN      6
`define SAS_SCR_CONT     5
`define SAS_CH_OFF       5'h1F
`define SAS_CH_COUNT     10
`define SAS_CLK_SRC      4
`define SAS_FULL_SCALE   10'h3FF
`define SAS_ZERO_SCALE   10'h000
`define SAS_CONV_CYCLES  5'h10
`define SAS_LAST_BIT     4'h9
`define SAS_SCR_RESET    8'h1F
`define SAS_MODE_LEFT    2'h0
`define SAS_MODE_RIGHT   2'h1
`define SAS_MODE_SIGNED  2'h2
`define SAS_MODE_TRUNC   2'h3
`endif

// File: core/sas_pkg.sv
/*
 Types shared by the converter sequencer.
 Assumes the constants header sits beside it.
*/
package sas_pkg;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} sas_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} sas_apb_rsp_t;

	typedef enum logic [1:0] {
		SAS_IDLE,
		SAS_SYNC,
		SAS_SAMPLE,
		SAS_OFF
	} sas_state_t;
endpackage : sas_pkg

// File: core/sas_sequencer.sv
/*
 Converter sequencer: APB registers, channel mux and pin takeover,
 clock select and divide, bit-by-bit approximation, result formatting.
 Assumes an analog comparator answers cmpHigh within the clock cycle in
 which the trial code and channel are presented, and that the oscillator
 clock arrives as a pin level to be sampled.
*/
`timescale 1ns/1ps
`include "sas_cfg.svh"
module sas_sequencer #(
	parameter int NCH = `SAS_CH_COUNT
) (
	input  wire logic                 clock,
	input  wire logic                 rst,
	input  wire sas_pkg::sas_apb_req_t apbReq,
	output      sas_pkg::sas_apb_rsp_t apbRsp,
	input  wire logic                 oscRefClock,
	input  wire logic                 cmpHigh,
	input  wire logic                 refHighSat,
	input  wire logic                 refLowSat,
	input  wire logic [NCH-1:0]       pinIn,
	output      logic [NCH-1:0]       pinOut,
	output      logic [NCH-1:0]       pinOe,
	output      logic [NCH-1:0]       analogSelect,
	output      logic [9:0]           trialCode,
	output      logic                 converterOn,
	output      logic                 convIrq
);
	import sas_pkg::*;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [NCH-1:0] chanOneHot(input logic [4:0] ch);
		logic [NCH-1:0] v;
		v = '0;
		for (int i = 0; i < NCH; i++)
		begin
			if (ch == 5'(i))
			begin
				v[i] = 1'b1;
			end
		end
		return v;
	endfunction : chanOneHot

	function automatic logic isAddr(input logic [11:0] a, input logic [11:0] o);
		return a == o;
	endfunction : isAddr

	// ----------------------------------------
	// Bus decode and registers
	// ----------------------------------------
	logic [7:0]     adc_status_control_reg;
	logic [7:0]     converter_clock_reg;
	logic [7:0]     result_high_reg;
	logic [7:0]     result_low_reg;
	logic [NCH-1:0] portData_reg;
	logic [NCH-1:0] portDir_reg;
	logic [NCH-1:0] pinMeta_reg;
	logic [NCH-1:0] pinSync_reg;
	logic           oscMeta_reg;
	logic           oscSync_reg;
	logic           oscPrev_reg;
	logic           highRead_reg;
	sas_state_t     state_reg;
	logic [3:0]     bitIdx_reg;
	logic [4:0]     cycCnt_reg;
	logic [9:0]     sar_reg;
	logic [7:0]     divCnt_reg;
	logic           firstDone_reg;

	logic           access;
	logic           wrScr;
	logic           rdResH;
	logic           rdResL;
	logic [4:0]     channelSel;
	logic [NCH-1:0] chanHot;
	logic           powered;
	logic           srcTick;
	logic           adcTick;
	logic           finish;
	logic [9:0]     finalCode;
	logic           interlocked;
	logic [1:0]     justifyMode;

	assign access      = apbReq.psel && apbReq.penable;
	assign wrScr       = access && apbReq.pwrite && isAddr(apbReq.paddr, `SAS_OFF_SCR);
	assign rdResH      = access && !apbReq.pwrite && isAddr(apbReq.paddr, `SAS_OFF_RESH);
	assign rdResL      = access && !apbReq.pwrite && isAddr(apbReq.paddr, `SAS_OFF_RESL);
	assign channelSel  = adc_status_control_reg[4:0];
	assign chanHot     = chanOneHot(channelSel);
	assign powered     = channelSel != `SAS_CH_OFF;
	assign justifyMode = converter_clock_reg[1:0];
	assign interlocked = justifyMode != `SAS_MODE_TRUNC;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			apbRsp <= '0;
		end
		else
		begin
			apbRsp.pready  <= apbReq.psel && !apbReq.penable;
			apbRsp.pslverr <= 1'b0;
			apbRsp.prdata  <= '0;
			if (apbReq.psel && !apbReq.penable && !apbReq.pwrite)
			begin
				case (apbReq.paddr)
					`SAS_OFF_SCR:     apbRsp.prdata <= {24'h000000, adc_status_control_reg};
					`SAS_OFF_RESH:    apbRsp.prdata <= {24'h000000, result_high_reg};
					`SAS_OFF_RESL:    apbRsp.prdata <= {24'h000000, result_low_reg};
					`SAS_OFF_CLKR:    apbRsp.prdata <= {24'h000000, converter_clock_reg};
					`SAS_OFF_PORTDAT: apbRsp.prdata <= 32'(portData_reg);
					`SAS_OFF_PORTDIR: apbRsp.prdata <= 32'(portDir_reg);
					`SAS_OFF_PORTIN:  apbRsp.prdata <= 32'(pinSync_reg & ~chanHot);
					default:          apbRsp.pslverr <= 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			converter_clock_reg <= 8'h00;
		end
		else if (access && apbReq.pwrite && isAddr(apbReq.paddr, `SAS_OFF_CLKR))
		begin
			converter_clock_reg <= apbReq.pwdata[7:0];
		end
	end

	// ----------------------------------------
	// Port logic and pin takeover
	// ----------------------------------------
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			portData_reg <= '0;
			portDir_reg  <= '0;
		end
		else if (access && apbReq.pwrite)
		begin
			// selected pin keeps its old port bits
			if (isAddr(apbReq.paddr, `SAS_OFF_PORTDAT))
			begin
				portData_reg <= (apbReq.pwdata[NCH-1:0] & ~chanHot) | (portData_reg & chanHot);
			end
			if (isAddr(apbReq.paddr, `SAS_OFF_PORTDIR))
			begin
				portDir_reg <= (apbReq.pwdata[NCH-1:0] & ~chanHot) | (portDir_reg & chanHot);
			end
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pinMeta_reg  <= '0;
			pinSync_reg  <= '0;
			oscMeta_reg  <= 1'b0;
			oscSync_reg  <= 1'b0;
			oscPrev_reg  <= 1'b0;
			pinOut       <= '0;
			pinOe        <= '0;
			analogSelect <= '0;
			converterOn  <= 1'b0;
		end
		else
		begin
			pinMeta_reg  <= pinIn;
			pinSync_reg  <= pinMeta_reg;
			oscMeta_reg  <= oscRefClock;
			oscSync_reg  <= oscMeta_reg;
			oscPrev_reg  <= oscSync_reg;
			pinOut       <= portData_reg;
			// converter owns the selected pin as input only
			pinOe        <= portDir_reg & ~chanHot;
			analogSelect <= chanHot;
			converterOn  <= powered;
		end
	end

	// ----------------------------------------
	// Converter clock
	// ----------------------------------------
	// source select then divide by ratio field plus one
	assign srcTick = converter_clock_reg[`SAS_CLK_SRC] ? (oscSync_reg && !oscPrev_reg) : 1'b1;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			divCnt_reg <= 8'h00;
		end
		else if (srcTick)
		begin
			divCnt_reg <= (divCnt_reg >= {5'h00, converter_clock_reg[7:5]}) ? 8'h00 : divCnt_reg + 8'h01;
		end
	end

	assign adcTick = srcTick && (divCnt_reg >= {5'h00, converter_clock_reg[7:5]});

	// ----------------------------------------
	// Approximation sequence
	// ----------------------------------------
	// saturation overrides the search
	assign finalCode = refHighSat ? `SAS_FULL_SCALE : (refLowSat ? `SAS_ZERO_SCALE : sar_reg);
	assign finish    = (state_reg == SAS_SAMPLE) && adcTick && (cycCnt_reg == `SAS_CONV_CYCLES);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_reg  <= SAS_OFF;
			bitIdx_reg <= 4'h0;
			cycCnt_reg <= 5'h00;
			sar_reg    <= 10'h000;
		end
		else if (wrScr)
		begin
			state_reg  <= (apbReq.pwdata[4:0] == `SAS_CH_OFF) ? SAS_OFF : SAS_SYNC;
			cycCnt_reg <= 5'h00;
			bitIdx_reg <= `SAS_LAST_BIT;
			sar_reg    <= 10'h200;
		end
		else
		begin
			case (state_reg)
				SAS_SYNC:
				begin
					if (adcTick)
					begin
						state_reg  <= SAS_SAMPLE;
						cycCnt_reg <= 5'h01;
					end
				end
				SAS_SAMPLE:
				begin
					if (adcTick)
					begin
						cycCnt_reg <= cycCnt_reg + 5'h01;
						if (cycCnt_reg <= 5'h0A)
						begin
							sar_reg[bitIdx_reg] <= cmpHigh;
							if (bitIdx_reg != 4'h0)
							begin
								sar_reg[bitIdx_reg - 4'h1] <= 1'b1;
								bitIdx_reg <= bitIdx_reg - 4'h1;
							end
						end
						if (finish)
						begin
							state_reg  <= adc_status_control_reg[`SAS_SCR_CONT] ? SAS_SAMPLE : SAS_IDLE;
							cycCnt_reg <= 5'h01;
							bitIdx_reg <= `SAS_LAST_BIT;
							sar_reg    <= 10'h200;
						end
					end
				end
				SAS_IDLE:   state_reg <= SAS_IDLE;
				SAS_OFF:    state_reg <= SAS_OFF;
				default:    state_reg <= SAS_IDLE;
			endcase
		end
	end

	// Trial code comes straight from the approximation flops so each decision sees it at once.
	assign trialCode = sar_reg;

	// ----------------------------------------
	// Results and interlock
	// ----------------------------------------
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			highRead_reg <= 1'b0;
		end
		else if (rdResL || wrScr)
		begin
			highRead_reg <= 1'b0;
		end
		else if (rdResH && interlocked)
		begin
			highRead_reg <= 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			result_high_reg <= 8'h00;
			result_low_reg  <= 8'h00;
		end
		// outside truncated mode, high read without low read blocks storing
		else if (finish && !(highRead_reg && interlocked))
		begin
			case (justifyMode)
				`SAS_MODE_LEFT:
				begin
					result_high_reg <= finalCode[9:2];
					result_low_reg  <= {finalCode[1:0], 6'h00};
				end
				`SAS_MODE_RIGHT:
				begin
					result_high_reg <= {6'h00, finalCode[9:8]};
					result_low_reg  <= finalCode[7:0];
				end
				`SAS_MODE_SIGNED:
				begin
					result_high_reg <= {~finalCode[9], finalCode[8:2]};
					result_low_reg  <= {finalCode[1:0], 6'h00};
				end
				default:
				begin
					result_high_reg <= 8'h00;
					result_low_reg  <= finalCode[9:2];
				end
			endcase
		end
	end

	// ----------------------------------------
	// Status register, flag and interrupt
	// ----------------------------------------
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			adc_status_control_reg <= `SAS_SCR_RESET;
			firstDone_reg          <= 1'b0;
			convIrq                <= 1'b0;
		end
		else
		begin
			if (wrScr)
			begin
				adc_status_control_reg <= {1'b0, apbReq.pwdata[6:0]};
				firstDone_reg          <= 1'b0;
				convIrq                <= 1'b0;
			end
			else if (finish)
			begin
				firstDone_reg <= 1'b1;
				if (adc_status_control_reg[`SAS_SCR_IEN])
				begin
					convIrq <= 1'b1;
				end
				// set only with interrupt enable clear; in continuous mode only on the first result
				else if (!firstDone_reg || !adc_status_control_reg[`SAS_SCR_CONT])
				begin
					adc_status_control_reg[`SAS_SCR_DONE] <= 1'b1;
				end
			end
			else if (rdResH || rdResL)
			begin
				adc_status_control_reg[`SAS_SCR_DONE] <= 1'b0;
				convIrq                               <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	pin_release_a: assert property (@(posedge clock) disable iff (rst)
		##1 !$past(apbReq.psel) |-> ((pinOe & $past(chanHot)) == '0))
		else $error("selected pin still driven");
	port_read_a: assert property (@(posedge clock) disable iff (rst)
		apbRsp.pready && $past(apbReq.paddr) == `SAS_OFF_PORTIN && !$past(apbReq.pwrite)
		|-> ((apbRsp.prdata[NCH-1:0] & $past(chanHot)) == '0))
		else $error("selected pin read not zero");
	start_sync_a: assert property (@(posedge clock) disable iff (rst)
		wrScr && apbReq.pwdata[4:0] != `SAS_CH_OFF |=> state_reg == SAS_SYNC)
		else $error("write did not start conversion");
	done_clear_a: assert property (@(posedge clock) disable iff (rst)
		wrScr |=> !adc_status_control_reg[`SAS_SCR_DONE] && !convIrq)
		else $error("flag survived status write");
	power_off_a: assert property (@(posedge clock) disable iff (rst)
		wrScr && apbReq.pwdata[4:0] == `SAS_CH_OFF |=> state_reg == SAS_OFF ##1 !converterOn)
		else $error("converter not switched off");
	irq_path_a: assert property (@(posedge clock) disable iff (rst)
		finish && adc_status_control_reg[`SAS_SCR_IEN] && !wrScr |=> convIrq)
		else $error("interrupt missing at finish");
	signed_fmt_a: assert property (@(posedge clock) disable iff (rst)
		finish && !highRead_reg && justifyMode == `SAS_MODE_SIGNED && !wrScr
		|=> result_high_reg[7] == ~$past(finalCode[9]))
		else $error("signed top bit wrong");
	right_fmt_a: assert property (@(posedge clock) disable iff (rst)
		finish && !highRead_reg && justifyMode == `SAS_MODE_RIGHT
		|=> result_low_reg == $past(finalCode[7:0]) && result_high_reg[7:2] == 6'h00)
		else $error("right format wrong");
endmodule : sas_sequencer

// File: dv/sas_analog_model.sv
/*
 Behavioural analog mux and comparator facing the sequencer.
 Assumes the bench sets one 10-bit level per channel.
*/
`timescale 1ns/1ps
module sas_analog_model
(
	input  wire logic        clock,
	input  wire logic [9:0]  analogSelect,
	input  wire logic [9:0]  trialCode,
	input  wire logic [99:0] levels,
	output      logic        cmpHigh
);
	logic [9:0] picked;
	logic       idleLevel = 1'b0;
	always_comb
	begin
		picked = 10'h000;
		for (int i = 0; i < 10; i++)
			if (analogSelect[i])
				picked = levels[i*10 +: 10];
	end
	// A deselected mux shows a toggling level so a stale answer is never trusted.
	always @(posedge clock)
	begin
		idleLevel <= ~idleLevel;
	end
	// linear compare, answered within the cycle
	assign cmpHigh = (analogSelect == 10'h000) ? idleLevel : (picked >= trialCode);
endmodule : sas_analog_model

// File: dv/sas_sequencer_tb.sv
/*
 Self-checking bench for the converter sequencer over APB.
 Assumes the analog model answers the comparator.
*/
`timescale 1ns/1ps
`include "sas_cfg.svh"
`define CHK(nm, ex, gt) \
	begin \
		totalChecks++; \
		if ((ex) !== (gt)) \
		begin \
			errTotal++; \
			$display("MISMATCH %s exp %h got %h", nm, ex, gt); \
		end \
	end
module sas_sequencer_tb;
	import sas_pkg::*;
	logic         clock = 1'b0;
	logic         rst = 1'b1;
	logic         osc = 1'b0;
	logic         hiSat = 1'b0;
	logic         loSat = 1'b0;
	logic [9:0]   pinIn = 10'h000;
	logic [99:0]  levels = '0;
	sas_apb_req_t req = '0;
	sas_apb_rsp_t rsp;
	logic [9:0]   pinOut, pinOe, anSel, trial;
	logic         cmp, convOn, irq;
	int           errTotal = 0;
	int           totalChecks = 0;
	int           seed = 32'h5f8e76ca;
	logic [32:0]  expQ[$];
	logic [32:0]  maskQ[$];
	logic [31:0]  q;
	logic [9:0]   v;
	int           ch;
	realtime      t0;
	always #5 clock = ~clock;
	always #37 osc = ~osc;
	sas_sequencer #(.NCH(10)) uut (.clock(clock), .rst(rst), .apbReq(req), .apbRsp(rsp),
		.oscRefClock(osc), .cmpHigh(cmp), .refHighSat(hiSat), .refLowSat(loSat),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .analogSelect(anSel),
		.trialCode(trial), .converterOn(convOn), .convIrq(irq));
	sas_analog_model model (.clock(clock), .analogSelect(anSel), .trialCode(trial),
		.levels(levels), .cmpHigh(cmp));
	// ----------------------------------------
	// Read result monitor
	// ----------------------------------------
	always @(posedge clock)
	begin
		if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1 && expQ.size() > 0)
		begin
			`CHK("read", expQ[0] & maskQ[0], {rsp.pslverr, rsp.prdata} & maskQ[0])
			void'(expQ.pop_front());
			void'(maskQ.pop_front());
		end
	end
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] ex, input logic [32:0] m);
		@(posedge clock);
		if (!w)
		begin
			expQ.push_back(ex);
			maskQ.push_back(m);
		end
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge clock);
		req.penable <= 1'b1;
		do
		begin
			@(posedge clock);
		end
		while (rsp.pready !== 1'b1);
		q = rsp.prdata;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic [32:0] m);
		apb(1'b0, a, 32'h0, {1'b0, ex}, m);
	endtask : rd
	task automatic waitDone();
		int n;
		n = 0;
		do
		begin
			apb(1'b0, `SAS_OFF_SCR, 32'h0, 33'h0, 33'h0);
			n++;
		end
		while (q[7] !== 1'b1 && n < 400);
		if (q[7] !== 1'b1)
			errTotal++;
	endtask : waitDone
	task automatic conv(input logic [7:0] ck, input int c, input logic [9:0] lv,
		input logic [9:0] ex);
		logic [15:0] r;
		levels[c*10 +: 10] <= lv;
		case (ck[1:0])
			2'h0: r = {ex[9:2], ex[1:0], 6'h00};
			2'h1: r = {6'h00, ex};
			2'h2: r = {~ex[9], ex[8:2], ex[1:0], 6'h00};
			default: r = {8'h00, ex[9:2]};
		endcase
		apb(1'b1, `SAS_OFF_CLKR, {24'h0, ck}, 33'h0, 33'h0);
		apb(1'b1, `SAS_OFF_SCR, c, 33'h0, 33'h0);
		waitDone();
		rd(`SAS_OFF_SCR, 32'h80 | c, 33'h1_0000_00FF);
		rd(`SAS_OFF_RESH, r[15:8], (ck[1:0] == 2'h3) ? 33'h0 : 33'h1_0000_00FF);
		rd(`SAS_OFF_RESL, r[7:0], 33'h1_0000_00FF);
		rd(`SAS_OFF_SCR, c, 33'h1_0000_00FF);
	endtask : conv
	task automatic wrapUp();
		if (errTotal == 0 && totalChecks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrapUp
	initial
	begin
		repeat (60000) @(posedge clock);
		errTotal++;
		wrapUp();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		rd(`SAS_OFF_SCR, 32'h1F, 33'h1_0000_00FF);
		`CHK("convOn", 1'b0, convOn)
		for (int m = 0; m < 12; m++)
		begin
			ch = unsigned'($random(seed)) % 10;
			v = (m % 3 == 0) ? 10'h3FF : (m % 3 == 1) ? 10'h000 : 10'($random(seed));
			conv(8'(m / 3), ch, v, v);
		end
		hiSat <= 1'b1;
		conv(8'h01, 6, 10'h200, 10'h3FF);
		hiSat <= 1'b0;
		loSat <= 1'b1;
		conv(8'h01, 7, 10'h200, 10'h000);
		loSat <= 1'b0;
		levels[20 +: 10] <= 10'h100;
		apb(1'b1, `SAS_OFF_SCR, 32'h2, 33'h0, 33'h0);
		conv(8'h01, 3, 10'h2A5, 10'h2A5);
		conv(8'h11, 9, 10'h1C3, 10'h1C3);
		apb(1'b1, `SAS_OFF_CLKR, 32'hE1, 33'h0, 33'h0);
		apb(1'b1, `SAS_OFF_SCR, 32'h9, 33'h0, 33'h0);
		t0 = $realtime;
		waitDone();
		`CHK("span", 1'b1, ($realtime - t0) >= 1280.0 && ($realtime - t0) <= 1600.0)
		apb(1'b1, `SAS_OFF_SCR, 32'h4, 33'h0, 33'h0);
		apb(1'b1, `SAS_OFF_PORTDIR, 32'h3FF, 33'h0, 33'h0);
		apb(1'b1, `SAS_OFF_PORTDAT, 32'h155, 33'h0, 33'h0);
		pinIn <= 10'h3FF;
		repeat (4) @(posedge clock);
		`CHK("pinOe", 10'h3EF, pinOe)
		`CHK("pinOut", 10'h145, pinOut)
		`CHK("anSel", 10'h010, anSel)
		rd(`SAS_OFF_PORTIN, 32'h3EF, 33'h1_0000_03FF);
		levels[10 +: 10] <= 10'h0F0;
		apb(1'b1, `SAS_OFF_SCR, 32'h41, 33'h0, 33'h0);
		for (int n = 0; n < 400 && irq !== 1'b1; n++)
			@(posedge clock);
		`CHK("irqSet", 1'b1, irq)
		rd(`SAS_OFF_SCR, 32'h41, 33'h1_0000_00FF);
		rd(`SAS_OFF_RESH, 32'h00, 33'h1_0000_00FF);
		rd(`SAS_OFF_RESL, 32'hF0, 33'h1_0000_00FF);
		`CHK("irq", 1'b0, irq)
		apb(1'b1, `SAS_OFF_CLKR, 32'h0, 33'h0, 33'h0);
		levels[50 +: 10] <= 10'h2C1;
		apb(1'b1, `SAS_OFF_SCR, 32'h25, 33'h0, 33'h0);
		waitDone();
		rd(`SAS_OFF_RESH, 32'hB0, 33'h1_0000_00FF);
		rd(`SAS_OFF_RESL, 32'h40, 33'h1_0000_00FF);
		rd(`SAS_OFF_SCR, 32'h25, 33'h1_0000_00FF);
		rd(`SAS_OFF_RESH, 32'hB0, 33'h1_0000_00FF);
		levels[50 +: 10] <= 10'h13E;
		repeat (150) @(posedge clock);
		rd(`SAS_OFF_RESL, 32'h40, 33'h1_0000_00FF);
		repeat (150) @(posedge clock);
		rd(`SAS_OFF_RESH, 32'h4F, 33'h1_0000_00FF);
		rd(`SAS_OFF_RESL, 32'h80, 33'h1_0000_00FF);
		apb(1'b1, `SAS_OFF_SCR, 32'h1F, 33'h0, 33'h0);
		repeat (3) @(posedge clock);
		`CHK("convOn", 1'b0, convOn)
		apb(1'b0, 12'h01C, 32'h0, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
		wrapUp();
	end
endmodule : sas_sequencer_tb
